/* rtl/cmo_defines.vh */
// constants shared by the cache maintenance unit: register map, fields and codes
`ifndef CMO_DEFINES_VH
`define CMO_DEFINES_VH
// ==========================================================
// register byte offsets on the axi4-lite slave
`define CMO_ADDR_CTRL 8'h00
`define CMO_ADDR_STATUS 8'h04
`define CMO_ADDR_TAGLO 8'h08
`define CMO_ADDR_TAGRD 8'h0c
`define CMO_ADDR_COUNT 8'h10
// ==========================================================
// control register bits and reset value
`define CMO_CTRL_WIDTH 4
`define CMO_CTRL_WB 0
`define CMO_CTRL_R6 1
`define CMO_CTRL_PIDX 2
`define CMO_CTRL_AEE 3
`define CMO_CTRL_RESET 4'h3
// ==========================================================
// line state bits in tag words
`define CMO_ST_V 0
`define CMO_ST_D 1
`define CMO_ST_L 2
// ==========================================================
// instruction fields
`define CMO_OP_HI 20
`define CMO_OP_LO 18
`define CMO_SEL_HI 17
`define CMO_SEL_LO 16
`define CMO_OFF9_HI 15
`define CMO_OFF9_LO 7
`define CMO_OFF16_HI 15
// ==========================================================
// operation codes
`define CMO_OP_IDX_WBINV 3'h0
`define CMO_OP_IDX_LDTAG 3'h1
`define CMO_OP_IDX_STTAG 3'h2
`define CMO_OP_IMPL 3'h3
`define CMO_OP_HIT_INV 3'h4
`define CMO_OP_HIT_WBINV 3'h5
`define CMO_OP_HIT_WB 3'h6
`define CMO_OP_FETCH_LOCK 3'h7
// ==========================================================
// cache select codes
`define CMO_SEL_I 2'h0
`define CMO_SEL_D 2'h1
`define CMO_SEL_T 2'h2
`define CMO_SEL_S 2'h3
// ==========================================================
// exception codes reported to the pipeline
`define CMO_EXC_NONE 3'h0
`define CMO_EXC_COP_UNUSABLE 3'h1
`define CMO_EXC_TLB_REFILL_LOAD 3'h2
`define CMO_EXC_TLB_INVALID_LOAD 3'h3
`define CMO_EXC_ADDR_ERR_LOAD 3'h4
`define CMO_EXC_CACHE_ERR 3'h5
`define CMO_EXC_BUS_ERR 3'h6
// ==========================================================
// axi response codes
`define CMO_RESP_OKAY 2'h0
`define CMO_RESP_SLVERR 2'h2
`endif

/* rtl/cmo_unit.v */
// cache maintenance operation unit with its data-cache tag store and axi4-lite registers
// What this block does
// - hit writeback keeps line valid, clears dirty
// - write-through cache makes hit writeback a nop
// - fetch-lock fills on miss, locks on hit
// - invalidates clear lock; tag store loads lock from taglo bit 2
// - fetch-lock touches one line only
// - unimplemented operation or cache does nothing
// - address operation on uncached address does nothing
// - coprocessor disabled raises coprocessor unusable
// - no alignment address error ever
// - address is base plus sign-extended offset
// - address operations use translated physical address
// - index operations translate; index source selectable
// - index and way taken from address bits
// - direct-mapped cache ignores way field
// - only load-cause translation exceptions raised
// - writeback errors cache error, fill errors bus error
// - tag load and store never cache error
// - kernel fault region may raise load address error
// - completion waits for every issued memory transfer
// - coherent hit writeback may broadcast
// - user variant translates with user mapping
// - cache chosen by instruction bits 17:16
// - cache select codes instruction data tertiary secondary
// - operation chosen by instruction bits 20:18
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`include "cmo_defines.vh"
module cmo_unit #(
  parameter CACHE_BYTES = 2048,
  parameter WAYS = 2,
  parameter LINE_BYTES = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire op_valid,
  output reg op_ready,
  input wire [31:0] op_instr,
  input wire [31:0] op_base,
  input wire user_space_cache_op,
  input wire cp0_enabled,
  output reg op_done,
  output reg op_exc,
  output reg [2:0] op_exc_code,
  output reg xlat_req,
  output reg [31:0] xlat_va,
  output reg xlat_user_map,
  input wire xlat_ack,
  input wire [31:0] xlat_pa,
  input wire xlat_refill,
  input wire xlat_invalid,
  input wire xlat_uncached,
  input wire xlat_coherent,
  input wire xlat_kernel_fault,
  output reg mem_req,
  output reg mem_write,
  output reg [31:0] mem_addr,
  input wire mem_ack,
  input wire mem_err,
  output reg coherent_bcast
);
  // ==========================================================
  // geometry
  localparam OFFB = $clog2(LINE_BYTES); // offset bit
  localparam IDXB = $clog2(CACHE_BYTES / WAYS); // index bit
  localparam SETS = (CACHE_BYTES / WAYS) / LINE_BYTES;
  localparam NLINES = SETS * WAYS;
  localparam LW = (NLINES > 1) ? $clog2(NLINES) : 1;
  // fsm states
  localparam ST_IDLE = 3'h0;
  localparam ST_XLAT = 3'h1;
  localparam ST_LOOK = 3'h2;
  localparam ST_WB = 3'h3;
  localparam ST_FILL = 3'h4;
  localparam ST_FIN = 3'h5;

  // ==========================================================
  // helper functions
  // line number of a given way at the set an address selects
  function [31:0] line_of(input [31:0] a, input [31:0] w);
    begin
      line_of = w * SETS + ((a >> OFFB) % SETS);
    end
  endfunction
  // tag part of an address, low bits cleared
  function [31:0] tag_of(input [31:0] a);
    begin
      tag_of = (a >> IDXB) << IDXB;
    end
  endfunction
  // way field of an index address
  function [31:0] way_of(input [31:0] a);
    begin
      way_of = (WAYS == 1) ? 32'h0 : ((a >> IDXB) % WAYS);
    end
  endfunction

  // ==========================================================
  // storage
  reg [31:0] tag_mem [0:NLINES-1]; // tag per line
  reg [NLINES-1:0] valid_vec; // line valid
  reg [NLINES-1:0] dirty_vec; // line dirty
  reg [NLINES-1:0] lock_vec; // line locked
  reg [`CMO_CTRL_WIDTH-1:0] ctrl_reg; // control bits
  reg [31:0] taglo_reg; // tag word for index store tag
  reg [31:0] tagrd_reg; // tag word from index load tag
  reg [31:0] count_reg; // completed operations
  reg [2:0] last_exc_reg; // last exception code
  reg [2:0] state_reg;
  reg [2:0] op_reg; // latched operation
  reg [1:0] sel_reg; // latched cache select
  reg [31:0] va_reg; // effective address
  reg [31:0] pa_reg; // translated address
  reg uncached_reg;
  reg coherent_reg;
  reg [2:0] exc_reg; // pending exception
  reg [LW-1:0] line_reg; // line being worked on
  // axi slave holding state
  reg aw_full;
  reg w_full;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  // lookup results
  reg hit;
  reg [LW-1:0] hit_line;
  reg vic_found;
  reg vic_free;
  reg [LW-1:0] vic_line;
  reg [LW-1:0] idx_line;
  reg [31:0] ln;
  reg [31:0] idx_addr;
  reg [31:0] wb_addr;
  reg [31:0] sext_off;
  integer w;
  integer i;

  // ==========================================================
  // combinational lookup of hit, victim and index line
  always @* begin
    hit = 1'b0;
    hit_line = {LW{1'b0}};
    vic_found = 1'b0;
    vic_free = 1'b0;
    vic_line = {LW{1'b0}};
    ln = 32'h0;
    // index source is selectable: virtual or translated
    idx_addr = ctrl_reg[`CMO_CTRL_PIDX] ? pa_reg : va_reg;
    for (w = 0; w < WAYS; w = w + 1) begin
      ln = line_of(pa_reg, w);
      if (valid_vec[ln[LW-1:0]] && tag_mem[ln[LW-1:0]] == tag_of(pa_reg)) begin
        hit = 1'b1;
        hit_line = ln[LW-1:0];
      end
      // prefer a free unlocked way, else first unlocked; locked ways never chosen
      if (!lock_vec[ln[LW-1:0]] && (!vic_found || (!vic_free && !valid_vec[ln[LW-1:0]]))) begin
        vic_found = 1'b1;
        vic_free = !valid_vec[ln[LW-1:0]];
        vic_line = ln[LW-1:0];
      end
    end
    ln = line_of(idx_addr, way_of(idx_addr));
    idx_line = ln[LW-1:0];
    // memory address of the line held in line_reg
    wb_addr = tag_mem[line_reg] | (((line_reg % SETS) << OFFB) & 32'hffffffff);
    // offset field width depends on the encoding generation
    if (ctrl_reg[`CMO_CTRL_R6]) begin
      sext_off = {{23{op_instr[`CMO_OFF9_HI]}}, op_instr[`CMO_OFF9_HI:`CMO_OFF9_LO]};
    end else begin
      sext_off = {{16{op_instr[`CMO_OFF16_HI]}}, op_instr[`CMO_OFF16_HI:0]};
    end
  end

  // ==========================================================
  // operation sequencer and tag store
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      op_exc <= 1'b0;
      op_exc_code <= `CMO_EXC_NONE;
      xlat_req <= 1'b0;
      xlat_va <= 32'h0;
      xlat_user_map <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 32'h0;
      coherent_bcast <= 1'b0;
      valid_vec <= {NLINES{1'b0}};
      dirty_vec <= {NLINES{1'b0}};
      lock_vec <= {NLINES{1'b0}};
      tagrd_reg <= 32'h0;
      count_reg <= 32'h0;
      last_exc_reg <= `CMO_EXC_NONE;
      op_reg <= 3'h0;
      sel_reg <= 2'h0;
      va_reg <= 32'h0;
      pa_reg <= 32'h0;
      uncached_reg <= 1'b0;
      coherent_reg <= 1'b0;
      exc_reg <= `CMO_EXC_NONE;
      line_reg <= {LW{1'b0}};
    end else begin
      op_done <= 1'b0;
      coherent_bcast <= 1'b0;
      case (state_reg)
        // accept one operation; no alignment check on the address
        ST_IDLE: begin
          op_ready <= 1'b1;
          op_exc <= 1'b0;
          if (op_valid && op_ready) begin
            op_ready <= 1'b0;
            op_reg <= op_instr[`CMO_OP_HI:`CMO_OP_LO];
            sel_reg <= op_instr[`CMO_SEL_HI:`CMO_SEL_LO];
            va_reg <= op_base + sext_off;
            exc_reg <= `CMO_EXC_NONE;
            if (!cp0_enabled) begin
              exc_reg <= `CMO_EXC_COP_UNUSABLE;
              state_reg <= ST_FIN;
            end else begin
              xlat_req <= 1'b1;
              xlat_va <= op_base + sext_off;
              xlat_user_map <= user_space_cache_op;
              state_reg <= ST_XLAT;
            end
          end
        end
        // every operation is translated as a data read; only load causes are raised
        ST_XLAT: begin
          if (xlat_ack) begin
            xlat_req <= 1'b0;
            pa_reg <= xlat_pa;
            uncached_reg <= xlat_uncached;
            coherent_reg <= xlat_coherent;
            if (xlat_kernel_fault && ctrl_reg[`CMO_CTRL_AEE]) begin
              exc_reg <= `CMO_EXC_ADDR_ERR_LOAD;
              state_reg <= ST_FIN;
            end else if (xlat_refill) begin
              exc_reg <= `CMO_EXC_TLB_REFILL_LOAD;
              state_reg <= ST_FIN;
            end else if (xlat_invalid) begin
              exc_reg <= `CMO_EXC_TLB_INVALID_LOAD;
              state_reg <= ST_FIN;
            end else begin
              state_reg <= ST_LOOK;
            end
          end
        end
        // decide the action from operation, cache and line state
        ST_LOOK: begin
          state_reg <= ST_FIN;
          if (sel_reg != `CMO_SEL_D) begin
            // only the primary data cache is present here
            state_reg <= ST_FIN;
          end else if (op_reg[2] && uncached_reg) begin
            state_reg <= ST_FIN;
          end else begin
            case (op_reg)
              `CMO_OP_IDX_WBINV: begin
                line_reg <= idx_line;
                if (valid_vec[idx_line] && dirty_vec[idx_line] && ctrl_reg[`CMO_CTRL_WB]) begin
                  state_reg <= ST_WB;
                end else begin
                  valid_vec[idx_line] <= 1'b0;
                  dirty_vec[idx_line] <= 1'b0;
                  lock_vec[idx_line] <= 1'b0;
                end
              end
              `CMO_OP_IDX_LDTAG: begin
                // diagnostic read, no memory traffic so no cache error
                tagrd_reg <= tag_mem[idx_line] | {29'h0, lock_vec[idx_line], dirty_vec[idx_line],
                  valid_vec[idx_line]};
              end
              `CMO_OP_IDX_STTAG: begin
                tag_mem[idx_line] <= tag_of(taglo_reg);
                valid_vec[idx_line] <= taglo_reg[`CMO_ST_V];
                dirty_vec[idx_line] <= taglo_reg[`CMO_ST_D];
                lock_vec[idx_line] <= taglo_reg[`CMO_ST_L];
              end
              `CMO_OP_HIT_INV: begin
                if (hit) begin
                  valid_vec[hit_line] <= 1'b0;
                  dirty_vec[hit_line] <= 1'b0;
                  lock_vec[hit_line] <= 1'b0;
                end
              end
              `CMO_OP_HIT_WBINV: begin
                line_reg <= hit_line;
                if (hit && dirty_vec[hit_line] && ctrl_reg[`CMO_CTRL_WB]) begin
                  state_reg <= ST_WB;
                end else if (hit) begin
                  valid_vec[hit_line] <= 1'b0;
                  dirty_vec[hit_line] <= 1'b0;
                  lock_vec[hit_line] <= 1'b0;
                end
              end
              `CMO_OP_HIT_WB: begin
                line_reg <= hit_line;
                // write-through: nothing to do
                if (ctrl_reg[`CMO_CTRL_WB] && hit && dirty_vec[hit_line]) begin
                  state_reg <= ST_WB;
                  coherent_bcast <= coherent_reg;
                end
              end
              `CMO_OP_FETCH_LOCK: begin
                if (hit) begin
                  lock_vec[hit_line] <= 1'b1;
                end else if (vic_found) begin
                  line_reg <= vic_line;
                  if (valid_vec[vic_line] && dirty_vec[vic_line]) begin
                    state_reg <= ST_WB;
                  end else begin
                    state_reg <= ST_FILL;
                  end
                end else begin
                  state_reg <= ST_FIN;
                end
              end
              default: begin
                state_reg <= ST_FIN;
              end
            endcase
          end
        end
        // write the line back and wait for the memory to finish
        ST_WB: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_write <= 1'b1;
            mem_addr <= wb_addr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            if (mem_err) begin
              exc_reg <= `CMO_EXC_CACHE_ERR;
              state_reg <= ST_FIN;
            end else if (op_reg == `CMO_OP_HIT_WB) begin
              dirty_vec[line_reg] <= 1'b0;
              state_reg <= ST_FIN;
            end else if (op_reg == `CMO_OP_FETCH_LOCK) begin
              valid_vec[line_reg] <= 1'b0;
              dirty_vec[line_reg] <= 1'b0;
              state_reg <= ST_FILL;
            end else begin
              valid_vec[line_reg] <= 1'b0;
              dirty_vec[line_reg] <= 1'b0;
              lock_vec[line_reg] <= 1'b0;
              state_reg <= ST_FIN;
            end
          end
        end
        // fetch the line and install it valid and locked
        ST_FILL: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_addr <= (pa_reg >> OFFB) << OFFB;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if (mem_err) begin
              exc_reg <= `CMO_EXC_BUS_ERR;
            end else begin
              tag_mem[line_reg] <= tag_of(pa_reg);
              valid_vec[line_reg] <= 1'b1;
              dirty_vec[line_reg] <= 1'b0;
              lock_vec[line_reg] <= 1'b1;
            end
            state_reg <= ST_FIN;
          end
        end
        // report completion, with exception if any
        ST_FIN: begin
          op_done <= 1'b1;
          op_exc <= (exc_reg != `CMO_EXC_NONE);
          op_exc_code <= exc_reg;
          last_exc_reg <= exc_reg;
          count_reg <= count_reg + 32'h1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // axi4-lite write side: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMO_RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      ctrl_reg <= `CMO_CTRL_RESET;
      taglo_reg <= 32'h0;
    end else begin
      // address channel
      if (s_axi_awready && s_axi_awvalid) begin
        aw_full <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_full && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      // data channel
      if (s_axi_wready && s_axi_wvalid) begin
        w_full <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_full && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      // perform the write once both halves are held
      if (aw_full && w_full && !s_axi_bvalid) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CMO_RESP_OKAY;
        case ({awaddr_reg[7:2], 2'h0})
          `CMO_ADDR_CTRL: begin
            if (wstrb_reg[0]) ctrl_reg <= wdata_reg[`CMO_CTRL_WIDTH-1:0];
          end
          `CMO_ADDR_TAGLO: begin
            for (i = 0; i < 4; i = i + 1) begin
              if (wstrb_reg[i]) taglo_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
            end
          end
          `CMO_ADDR_STATUS, `CMO_ADDR_TAGRD, `CMO_ADDR_COUNT: begin
            s_axi_bresp <= `CMO_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `CMO_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CMO_RESP_OKAY;
    end else begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CMO_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'h0})
          `CMO_ADDR_CTRL: s_axi_rdata <= {28'h0, ctrl_reg};
          `CMO_ADDR_STATUS: s_axi_rdata <= {28'h0, last_exc_reg, (state_reg != ST_IDLE)};
          `CMO_ADDR_TAGLO: s_axi_rdata <= taglo_reg;
          `CMO_ADDR_TAGRD: s_axi_rdata <= tagrd_reg;
          `CMO_ADDR_COUNT: s_axi_rdata <= count_reg;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CMO_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // cmo_unit

/* bench/cmo_unit_checker.sv */
// assertion checker for the cache maintenance unit ports
module cmo_unit_checker (
  input wire aclk,
  input wire aresetn,
  input wire op_valid,
  input wire op_ready,
  input wire [31:0] op_instr,
  input wire cp0_enabled,
  input wire op_done,
  input wire op_exc,
  input wire [2:0] op_exc_code,
  input wire xlat_req,
  input wire xlat_ack,
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire mem_err,
  input wire coherent_bcast
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [2:0] op_q; // operation code of the op in flight
  wire take = op_valid && op_ready;
  // ==========================================
  // remember the operation at the take edge
  always @(posedge aclk) begin
    if (!aresetn) op_q <= 3'h0;
    else if (take) op_q <= op_instr[20:18];
  end
  sequence s_wb_issue;
    ##1 (mem_req && mem_write);
  endsequence
  sequence s_cop_done;
    ##1 (op_done && op_exc && op_exc_code == 3'h1);
  endsequence
  property p_cop; take && !cp0_enabled |=> !xlat_req ##0 s_cop_done; endproperty
  a_cop: assert property (p_cop) else $error("coprocessor exception missing");
  property p_code; op_done |-> (op_exc == (op_exc_code != 3'h0)) && op_exc_code != 3'h7; endproperty
  a_code: assert property (p_code) else $error("bad exception code");
  property p_tag; op_done && (op_q == 3'h1 || op_q == 3'h2) |-> op_exc_code != 3'h5; endproperty
  a_tag: assert property (p_tag) else $error("cache error on tag op");
  property p_sel; take && cp0_enabled && op_instr[17:16] != 2'h1 |=> !mem_req [*6]; endproperty
  a_sel: assert property (p_sel) else $error("memory used by other cache");
  property p_xhold; xlat_req && !xlat_ack |=> xlat_req; endproperty
  a_xhold: assert property (p_xhold) else $error("translation request dropped");
  property p_mhold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write); endproperty
  a_mhold: assert property (p_mhold) else $error("memory request changed");
  property p_wberr; mem_req && mem_ack && mem_err && mem_write |-> ##[1:3] (op_done && op_exc_code == 3'h5); endproperty
  a_wberr: assert property (p_wberr) else $error("writeback error not reported");
  property p_flerr; mem_req && mem_ack && mem_err && !mem_write |-> ##[1:3] (op_done && op_exc_code == 3'h6); endproperty
  a_flerr: assert property (p_flerr) else $error("fill error not reported");
  property p_bcast; coherent_bcast |-> op_q == 3'h6 ##0 s_wb_issue; endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast without writeback");
  property p_idle; op_done |-> !mem_req && !xlat_req; endproperty
  a_idle: assert property (p_idle) else $error("done with transfer open");
endmodule // cmo_unit_checker
bind cmo_unit cmo_unit_checker u_chk (.aclk, .aresetn, .op_valid, .op_ready, .op_instr, .cp0_enabled, .op_done,
  .op_exc, .op_exc_code, .xlat_req, .xlat_ack, .mem_req, .mem_write, .mem_addr, .mem_ack, .mem_err, .coherent_bcast);

/* bench/cmo_far_model.sv */
// translator and next-level memory model on the unit's far side
module cmo_far_model (
  input wire logic aclk,
  input wire logic xlat_req,
  input wire logic [31:0] xlat_va,
  input wire logic mem_req,
  input wire logic slow,
  input wire logic [5:0] fault,
  output logic xlat_ack,
  output logic [31:0] xlat_pa,
  output logic [4:0] xf,
  output logic mem_ack,
  output logic mem_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] xc = 2'h0; // cycles the translation request waited
  logic [1:0] mc = 2'h0; // cycles the memory request waited
  // payload valid only with its ack, else inverted
  assign xlat_pa = xlat_ack ? xlat_va : ~xlat_va;
  assign xf = xlat_ack ? fault[4:0] : ~fault[4:0];
  assign mem_err = mem_ack ? fault[5] : ~fault[5];
  // one-cycle acks after zero or three waits
  always @(posedge aclk) begin
    xlat_ack <= xlat_req && !xlat_ack && xc >= {slow, slow};
    xc <= (xlat_req && !xlat_ack) ? xc + 2'h1 : 2'h0;
    mem_ack <= mem_req && !mem_ack && mc >= {slow, slow};
    mc <= (mem_req && !mem_ack) ? mc + 2'h1 : 2'h0;
  end
endmodule // cmo_far_model

/* bench/cmo_unit_tb.sv */
// self-checking bench for the cache maintenance unit
module cmo_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic op_valid, user_space_cache_op, cp0_enabled, slow, last_um;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, op_instr, op_base, last_va, last_ma, d;
  logic [3:0] s_axi_wstrb;
  logic [5:0] fault;
  logic [8:0] off;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_ready, op_done, op_exc;
  wire xlat_req, xlat_user_map, xlat_ack, mem_req, mem_write, mem_ack, mem_err, coherent_bcast;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [2:0] op_exc_code;
  wire [4:0] xf;
  wire [31:0] s_axi_rdata, xlat_va, xlat_pa, mem_addr;
  int n_fail = 0, n_tests = 0, n_wr = 0, n_rd = 0;
  // row: cp0 enable, fault, op, cache select, expected code
  localparam logic [23:0] TBL [10] = '{24'h000711, 24'h101712, 24'h103712, 24'h102713, 24'h111714,
    24'h104710, 24'h100700, 24'h100720, 24'h100730, 24'h100310};
  cmo_unit dut (.*, .xlat_refill(xf[0]), .xlat_invalid(xf[1]), .xlat_uncached(xf[2]), .xlat_coherent(xf[3]),
    .xlat_kernel_fault(xf[4]));
  cmo_far_model u_far (.aclk, .xlat_req, .xlat_va, .mem_req, .slow, .fault, .xlat_ack, .xlat_pa, .xf, .mem_ack,
    .mem_err);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // watchdog against a hang
  initial begin
    #1000000;
    n_fail++;
    end_sim;
  end
  // count memory transfers, note translations
  always @(posedge aclk) begin
    if (mem_req && mem_ack && mem_write) n_wr++;
    if (mem_req && mem_ack && !mem_write) n_rd++;
    if (mem_req) last_ma = mem_addr;
    if (xlat_req) begin
      last_va = xlat_va;
      last_um = xlat_user_map;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ws(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, e});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic op(input logic [2:0] c, input logic [1:0] s, input logic [31:0] b, input logic [2:0] e);
    op_instr <= {11'h0, c, s, off, 7'h0};
    op_base <= b;
    op_valid <= 1'b1;
    do begin
      @(posedge aclk);
      if (op_ready) op_valid <= 1'b0;
    end while (!op_done);
    chk({29'h0, op_exc_code}, {29'h0, e});
    @(posedge aclk);
  endtask
  // load a line's tag, compare its state bits
  task automatic tag(input logic [31:0] a, input logic [2:0] e);
    op(3'h1, 2'h1, a, 3'h0);
    rd(8'h0c);
    chk({29'h0, d[2:0]}, {29'h0, e});
  endtask
  // ==========================================
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, op_valid} = '0;
    {user_space_cache_op, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata, op_instr, op_base, fault, off} = '0;
    s_axi_wstrb = 4'hf;
    cp0_enabled = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(8'h00);
    chk(d, 32'h3);
    rd(8'h40);
    chk({30'h0, r}, 32'h2);
    ws(8'h40, 32'h1, 2'h2);
    ws(8'h08, 32'h3, 2'h0);
    op(3'h2, 2'h1, 32'h50, 3'h0);
    ws(8'h08, 32'h0, 2'h0);
    op(3'h2, 2'h1, 32'h450, 3'h0);
    tag(32'h50, 3'h3);
    fault <= 6'h08;
    slow <= 1'b1;
    op(3'h6, 2'h1, 32'h5c, 3'h0);
    chk(n_wr, 1);
    chk(last_ma, 32'h50);
    tag(32'h50, 3'h1);
    op(3'h6, 2'h1, 32'h50, 3'h0);
    op(3'h7, 2'h1, 32'h50, 3'h0);
    tag(32'h50, 3'h5);
    op(3'h4, 2'h1, 32'h50, 3'h0);
    tag(32'h50, 3'h0);
    op(3'h7, 2'h1, 32'h54, 3'h0);
    tag(32'h50, 3'h5);
    tag(32'h450, 3'h0);
    op(3'h0, 2'h1, 32'h50, 3'h0);
    tag(32'h50, 3'h0);
    ws(8'h00, 32'h2, 2'h0);
    ws(8'h08, 32'h3, 2'h0);
    op(3'h2, 2'h1, 32'h50, 3'h0);
    op(3'h6, 2'h1, 32'h50, 3'h0);
    chk(n_wr + n_rd, 2);
    ws(8'h00, 32'hb, 2'h0);
    fault <= 6'h20;
    op(3'h6, 2'h1, 32'h50, 3'h5);
    op(3'h7, 2'h1, 32'h60, 3'h6);
    rd(8'h04);
    chk(d, 32'hc);
    tag(32'h60, 3'h0);
    foreach (TBL[i]) begin
      cp0_enabled <= TBL[i][20];
      fault <= TBL[i][17:12];
      slow <= i[0];
      op(TBL[i][10:8], TBL[i][5:4], 32'h70, TBL[i][2:0]);
    end
    chk(n_wr + n_rd, 4);
    cp0_enabled <= 1'b1;
    fault <= 6'h00;
    user_space_cache_op <= 1'b1;
    off = 9'h1f0;
    op(3'h1, 2'h1, 32'h80, 3'h0);
    chk(last_va, 32'h70);
    chk({31'h0, last_um}, 32'h1);
    rd(8'h10);
    chk(d, 32'h1f);
    end_sim;
  end
endmodule // cmo_unit_tb
